// ### rtl/sync_channel_pkg.sv
// Shared constants and carrier types for the synchronous RS422 channel block.
package sync_channel_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_HZ = 200000000;
  localparam int unsigned BAUD_HZ = 64000;
  localparam int unsigned OVERSAMPLE = 16;
  // System clocks per oversampling tick, rounded down.
  localparam int unsigned TICK_CYCLES = SYS_CLK_HZ / (BAUD_HZ * OVERSAMPLE);
  localparam int unsigned TICK_W = 8;
  localparam int unsigned PHASE_W = 4;
  localparam logic [PHASE_W-1:0] PHASE_SAMPLE = 4'h8;
  localparam logic [PHASE_W-1:0] PHASE_CLK_RISE = 4'h8;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 4'hf;
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 4'h0;
  localparam logic [PHASE_W-1:0] PHASE_STEP = 4'h1;
  localparam int unsigned CHANNELS = 2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic data;
    logic valid;
  } bit_strobe_t;

  typedef struct packed {
    logic rx_clk;
    logic rx_bit;
    logic rx_valid;
  } rx_recovered_t;

endpackage : sync_channel_pkg

// ### rtl/nrzi_dpll_rx.sv
// Receive path of one channel: 16x DPLL clock recovery and NRZI-mark decode.
`timescale 1ns/10ps
`default_nettype none

module nrzi_dpll_rx #(
  parameter int unsigned TICK_CYCLES = sync_channel_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic line_i,
  output sync_channel_pkg::rx_recovered_t rx_o
);

  logic [sync_channel_pkg::TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic [sync_channel_pkg::PHASE_W-1:0] phase_q, phase_d;
  logic prev_line_q, prev_line_d;
  logic prev_sample_q, prev_sample_d;
  sync_channel_pkg::rx_recovered_t out_q, out_d;
  logic tick;

  // ****************************************************************
  // Oversampling DPLL
  // ****************************************************************
  always_comb begin
    tick = (tick_cnt_q == tick_last());
    tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
    phase_d = phase_q;
    prev_line_d = prev_line_q;
    prev_sample_d = prev_sample_q;
    out_d = out_q;
    out_d.rx_valid = 1'b0;
    if (tick) begin
      prev_line_d = line_i;
      // A line edge realigns the phase so sampling falls mid-cell.
      if (line_i != prev_line_q) begin
        phase_d = sync_channel_pkg::PHASE_STEP;
      end else begin
        phase_d = phase_q + sync_channel_pkg::PHASE_STEP;
      end
      out_d.rx_clk = (phase_q >= sync_channel_pkg::PHASE_CLK_RISE);
      // An edge at the sample point means the cell is not centred yet, so that sample is skipped.
      if ((phase_q == sync_channel_pkg::PHASE_SAMPLE) && (line_i == prev_line_q)) begin
        // A transition since the last sample decodes as one.
        out_d.rx_bit = (line_i != prev_sample_q);
        out_d.rx_valid = 1'b1;
        prev_sample_d = line_i;
      end
    end
  end

  function automatic logic [sync_channel_pkg::TICK_W-1:0] tick_last();
    tick_last = sync_channel_pkg::TICK_W'(TICK_CYCLES - 1);
  endfunction : tick_last

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tick_cnt_q <= '0;
      phase_q <= sync_channel_pkg::PHASE_ZERO;
      prev_line_q <= 1'b0;
      prev_sample_q <= 1'b0;
      out_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      phase_q <= phase_d;
      prev_line_q <= prev_line_d;
      prev_sample_q <= prev_sample_d;
      out_q <= out_d;
    end
  end

  assign rx_o = out_q;

endmodule : nrzi_dpll_rx

`default_nettype wire

// ### rtl/rs422_sync_channel_nrzi_dpll.sv
// Top of the two-channel synchronous RS422 link with NRZI-mark coding.
`timescale 1ns/10ps
`default_nettype none

module rs422_sync_channel_nrzi_dpll #(
  parameter int unsigned TICK_CYCLES = sync_channel_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic send_timing_pos_i,
  input wire logic three_terminal_i,
  input wire logic [sync_channel_pkg::CHANNELS-1:0] tx_bit_i,
  input wire logic [sync_channel_pkg::CHANNELS-1:0] rx_line_i,
  output logic [sync_channel_pkg::CHANNELS-1:0] tx_line_o,
  output logic [sync_channel_pkg::CHANNELS-1:0] tx_bit_taken_o,
  output logic [sync_channel_pkg::CHANNELS-1:0] rx_clk_o,
  output logic [sync_channel_pkg::CHANNELS-1:0] rx_bit_o,
  output logic [sync_channel_pkg::CHANNELS-1:0] rx_valid_o
);

  localparam int unsigned N = sync_channel_pkg::CHANNELS;

  // Channel one always runs; channel two only joins in three-terminal use.
  function automatic logic chan_enabled(input int unsigned idx, input logic three_term);
    chan_enabled = (idx == 0) || three_term;
  endfunction : chan_enabled

  // ****************************************************************
  // Send-timing synchroniser and edge finder
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10
  } st_level_t;

  logic [1:0] st_meta_q;
  logic [1:0] st_meta_d;
  st_level_t st_level_q;
  st_level_t st_level_d;
  logic st_fall;

  // Starting in the low state means a pin already high at reset gives no false launch.
  always_comb begin
    st_meta_d = {st_meta_q[0], send_timing_pos_i};
    st_level_d = st_level_q;
    st_fall = 1'b0;
    case (st_level_q)
      ST_LOW: begin
        if (st_meta_q[1]) begin
          st_level_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (!st_meta_q[1]) begin
          st_level_d = ST_LOW;
          st_fall = 1'b1;
        end
      end
      default: begin
        st_level_d = ST_LOW;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_meta_q <= '0;
      st_level_q <= ST_LOW;
    end else begin
      st_meta_q <= st_meta_d;
      st_level_q <= st_level_d;
    end
  end

  // ****************************************************************
  // Mode synchroniser and channel enables
  // ****************************************************************
  logic mode_meta_q;
  logic mode_meta_d;
  logic mode_sync_q;
  logic mode_sync_d;
  logic [N-1:0] chan_en;

  always_comb begin
    mode_meta_d = three_terminal_i;
    mode_sync_d = mode_meta_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mode_meta_q <= 1'b0;
      mode_sync_q <= 1'b0;
    end else begin
      mode_meta_q <= mode_meta_d;
      mode_sync_q <= mode_sync_d;
    end
  end

  // A mode change acts at once, so a bit in flight on channel two may be cut short.
  always_comb begin
    for (int unsigned i = 0; i < N; i++) begin
      chan_en[i] = chan_enabled(i, mode_sync_q);
    end
  end

  // ****************************************************************
  // Receive line synchronisers
  // ****************************************************************
  logic [N-1:0] rx_meta_q;
  logic [N-1:0] rx_meta_d;
  logic [N-1:0] rx_sync_q;
  logic [N-1:0] rx_sync_d;

  always_comb begin
    rx_meta_d = rx_line_i;
    rx_sync_d = rx_meta_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_meta_q <= '0;
      rx_sync_q <= '0;
    end else begin
      rx_meta_q <= rx_meta_d;
      rx_sync_q <= rx_sync_d;
    end
  end

  // ****************************************************************
  // Transmit, NRZI-mark encode on the send-timing clock
  // ****************************************************************
  for (genvar g = 0; g < N; g++) begin : g_tx
    logic line_q;
    logic line_d;
    logic taken_q;
    logic taken_d;

    always_comb begin
      line_d = line_q;
      taken_d = 1'b0;
      // Launching on the falling edge centres the rising edge in the bit.
      if (st_fall && chan_en[g]) begin
        line_d = line_q ^ tx_bit_i[g];
        taken_d = 1'b1;
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
        line_q <= 1'b0;
        taken_q <= 1'b0;
      end else begin
        line_q <= line_d;
        taken_q <= taken_d;
      end
    end

    assign tx_line_o[g] = line_q;
    assign tx_bit_taken_o[g] = taken_q;
  end

  // ****************************************************************
  // Receive, one DPLL per channel
  // ****************************************************************
  for (genvar g = 0; g < N; g++) begin : g_rx
    sync_channel_pkg::rx_recovered_t rec;
    logic clk_q;
    logic clk_d;
    logic data_q;
    logic data_d;
    logic valid_q;
    logic valid_d;

    // The loop keeps running while its channel is off, so it is locked when enabled.
    nrzi_dpll_rx #(
      .TICK_CYCLES(TICK_CYCLES)
    ) u_rx (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .line_i(rx_sync_q[g]),
      .rx_o(rec)
    );

    always_comb begin
      // Recovered clock drives the controller receive side.
      clk_d = rec.rx_clk & chan_en[g];
      data_d = rec.rx_bit;
      valid_d = rec.rx_valid & chan_en[g];
    end

    always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
        clk_q <= 1'b0;
        data_q <= 1'b0;
        valid_q <= 1'b0;
      end else begin
        clk_q <= clk_d;
        data_q <= data_d;
        valid_q <= valid_d;
      end
    end

    assign rx_clk_o[g] = clk_q;
    assign rx_bit_o[g] = data_q;
    assign rx_valid_o[g] = valid_q;
  end

endmodule : rs422_sync_channel_nrzi_dpll

`default_nettype wire

// ### bench/mux_partner.sv
// Far-side model: data module giving one send-timing clock and two NRZI lines.
`timescale 1ns/10ps
`default_nettype none
module mux_partner (
  input wire logic clk_i,
  input wire logic [1:0] tx_line_i,
  output logic st_o,
  output logic [1:0] line_o
);
  logic [15:0] g0 = 16'h0;
  logic [15:0] g1 = 16'h0;
  logic [1:0] prv = 2'h0;
  // One free-running source times both channels, so they cannot drift apart.
  initial begin
    st_o = 1'b0;
    line_o = 2'h0;
    #17;
    forever #62.5 st_o = ~st_o;
  end
  always @(posedge st_o) begin
    g0 <= {g0[14:0], tx_line_i[0] ^ prv[0]};
    g1 <= {g1[14:0], tx_line_i[1] ^ prv[1]};
    prv <= tx_line_i;
  end
  task automatic send(input logic [7:0] a, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk_i);
      line_o = line_o ^ {b[i], a[i]};
      repeat (63) @(negedge clk_i);
    end
  endtask : send
endmodule : mux_partner
`default_nettype wire

// ### bench/sync_channel_sva.sv
// Concurrent checks on the ports of the synchronous channel top.
`timescale 1ns/10ps
`default_nettype none
module sync_channel_sva #(
  parameter int unsigned TICK_CYCLES = sync_channel_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic send_timing_pos_i,
  input wire logic three_terminal_i,
  input wire logic [1:0] tx_bit_i,
  input wire logic [1:0] rx_line_i,
  input wire logic [1:0] tx_line_o,
  input wire logic [1:0] tx_bit_taken_o,
  input wire logic [1:0] rx_clk_o,
  input wire logic [1:0] rx_bit_o,
  input wire logic [1:0] rx_valid_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  property p_code0; tx_bit_taken_o[0] |-> tx_line_o[0] == ($past(tx_line_o[0]) ^ $past(tx_bit_i[0])); endproperty
  a_code0: assert property (p_code0) else $error("channel 0 line coding wrong");
  property p_code1; tx_bit_taken_o[1] |-> tx_line_o[1] == ($past(tx_line_o[1]) ^ $past(tx_bit_i[1])); endproperty
  a_code1: assert property (p_code1) else $error("channel 1 line coding wrong");
  property p_hold0; !tx_bit_taken_o[0] |-> $stable(tx_line_o[0]); endproperty
  a_hold0: assert property (p_hold0) else $error("line moved without a taken bit");
  property p_st; tx_bit_taken_o[0] |-> !send_timing_pos_i && !$past(send_timing_pos_i, 3); endproperty
  a_st: assert property (p_st) else $error("bit taken outside the low clock phase");
  property p_pair; three_terminal_i [*8] ##0 tx_bit_taken_o[0] |-> tx_bit_taken_o[1]; endproperty
  a_pair: assert property (p_pair) else $error("channels not launched together");
  property p_off; !three_terminal_i [*8] |-> !tx_bit_taken_o[1] && !rx_valid_o[1] && !rx_clk_o[1]; endproperty
  a_off: assert property (p_off) else $error("channel 1 active while unused");
  property p_rxv; rx_valid_o[0] |=> !rx_valid_o[0]; endproperty
  a_rxv: assert property (p_rxv) else $error("receive strobe longer than one cycle");
  property p_rxc; rx_valid_o[0] |-> rx_clk_o[0]; endproperty
  a_rxc: assert property (p_rxc) else $error("receive bit without recovered clock high");
  c_tx1: cover property (tx_bit_taken_o[1]);
  c_rx1: cover property (rx_valid_o[0] && rx_bit_o[0]);
  c_off: cover property (!three_terminal_i && tx_bit_taken_o[0]);
endmodule : sync_channel_sva
bind rs422_sync_channel_nrzi_dpll sync_channel_sva #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .send_timing_pos_i(send_timing_pos_i), .three_terminal_i(three_terminal_i),
  .tx_bit_i(tx_bit_i), .rx_line_i(rx_line_i), .tx_line_o(tx_line_o), .tx_bit_taken_o(tx_bit_taken_o),
  .rx_clk_o(rx_clk_o), .rx_bit_o(rx_bit_o), .rx_valid_o(rx_valid_o));
`default_nettype wire

// ### bench/tb.sv
// Testbench for the two-channel synchronous RS422 link.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tt = 1'b1;
  logic [1:0] txb = 2'h0;
  logic [1:0] txl, tkn, rxc, rxb, rxv, line;
  logic st;
  logic [15:0] r0 = 16'h0;
  logic [15:0] r1 = 16'h0;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam int unsigned TB_TICK = 4;
  always #2.5 clk = ~clk;
  mux_partner mp (.clk_i(clk), .tx_line_i(txl), .st_o(st), .line_o(line));
  // A short tick keeps the receive bit at 64 clocks so the run stays brief.
  rs422_sync_channel_nrzi_dpll #(.TICK_CYCLES(TB_TICK)) uut (.sys_clk_i(clk), .reset_i(rst), .send_timing_pos_i(st),
    .three_terminal_i(tt), .tx_bit_i(txb), .rx_line_i(line), .tx_line_o(txl), .tx_bit_taken_o(tkn),
    .rx_clk_o(rxc), .rx_bit_o(rxb), .rx_valid_o(rxv));
  always @(posedge clk) begin
    if (rxv[0]) r0 <= {r0[14:0], rxb[0]};
    if (rxv[1]) r1 <= {r1[14:0], rxb[1]};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tx_test(input logic [7:0] a, input logic [7:0] b);
    int w;
    for (int i = 7; i >= 0; i--) begin
      txb = {b[i], a[i]};
      w = 0;
      while (tkn[0] !== 1'b1 && w < 200) begin
        @(negedge clk);
        w++;
      end
      chk("taken1", {15'h0, tkn[1]}, 16'h1);
      @(negedge clk);
    end
    @(posedge st);
    @(negedge clk);
    chk("tx0", {8'h0, mp.g0[7:0]}, {8'h0, a});
    chk("tx1", {8'h0, mp.g1[7:0]}, {8'h0, b});
    $display("tx test done");
  endtask : tx_test
  task automatic two_term_test();
    logic l1;
    int n0, n1;
    n0 = 0;
    n1 = 0;
    tt = 1'b0;
    repeat (10) @(negedge clk);
    l1 = txl[1];
    txb = 2'h3;
    repeat (100) begin
      @(negedge clk);
      n0 += tkn[0];
      n1 += tkn[1] + rxv[1];
    end
    chk("ch0 runs", {15'h0, n0 > 2}, 16'h1);
    chk("ch1 idle", n1[15:0], 16'h0);
    chk("line1", {15'h0, txl[1]}, {15'h0, l1});
    tt = 1'b1;
    $display("two terminal test done");
  endtask : two_term_test
  task automatic rx_test();
    int p;
    mp.send(8'h91, 8'hd6);
    chk("rx0", {8'h0, r0[7:0]}, 16'h91);
    chk("rx1", {8'h0, r1[7:0]}, 16'hd6);
    // An idle line leaves the loop free-running, so recovered clock rises are 16 ticks apart.
    p = 0;
    while (rxc[0] !== 1'b0 && p < 200) begin
      @(negedge clk);
      p++;
    end
    while (rxc[0] !== 1'b1 && p < 200) begin
      @(negedge clk);
      p++;
    end
    p = 0;
    while (rxc[0] !== 1'b0 && p < 200) begin
      @(negedge clk);
      p++;
    end
    while (rxc[0] !== 1'b1 && p < 200) begin
      @(negedge clk);
      p++;
    end
    chk("rx clock period", p[15:0], 16'(sync_channel_pkg::OVERSAMPLE * TB_TICK));
    $display("rx test done");
  endtask : rx_test
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    tx_test(8'hb2, 8'h4d);
    two_term_test();
    rx_test();
    final_report();
  end
endmodule : tb
`default_nettype wire
